// [verilog/mbsync_params.svh]
`ifndef MBSYNC_PARAMS_SVH
`define MBSYNC_PARAMS_SVH
`define MBSYNC_ADDR_W 4
`define MBSYNC_OFS_COMMAND 4'h0
`define MBSYNC_OFS_STATUS 4'h4
`define MBSYNC_OFS_RUN_CYCLES 4'h8
`define MBSYNC_CMD_RUN 32'h0000000A
`define MBSYNC_CMD_RUN_BLOCKING 32'h0000000B
`define MBSYNC_CMD_CLK_MASTER_STD 32'h00000064
`define MBSYNC_CMD_TRIG_LEADER 32'h00000065
`define MBSYNC_CMD_CLK_MASTER_STREAM 32'h00000066
`define MBSYNC_CMD_CLK_SLAVE_STD 32'h0000006E
`define MBSYNC_CMD_TRIG_FOLLOWER 32'h0000006F
`define MBSYNC_CMD_ARM_GROUP 32'h00000082
`define MBSYNC_ST_DONE_BIT 0
`define MBSYNC_ST_RUNNING_BIT 1
`define MBSYNC_ST_ARMED_BIT 2
`define MBSYNC_ST_ERR_BIT 3
`define MBSYNC_ST_CLK_LSB 4
`define MBSYNC_ST_TRIG_LSB 6
`define MBSYNC_ST_BLOCK_BIT 8
`define MBSYNC_RUN_CYCLES_RST 32'h00000010
`endif

// [verilog/mbsync_pkg.sv]
`default_nettype none
package mbsync_pkg;
  typedef enum logic [1:0] {
    MBSYNC_CLK_NONE = 2'b00,
    MBSYNC_CLK_MASTER_STD = 2'b01,
    MBSYNC_CLK_MASTER_STREAM = 2'b10,
    MBSYNC_CLK_SLAVE_STD = 2'b11
  } mbsync_clk_role_type;
  typedef enum logic [1:0] {
    MBSYNC_TRIG_NONE = 2'b00,
    MBSYNC_TRIG_LEADER = 2'b01,
    MBSYNC_TRIG_FOLLOWER = 2'b10
  } mbsync_trig_role_type;
  typedef enum logic [1:0] {
    MBSYNC_IDLE = 2'b00,
    MBSYNC_ARMED = 2'b01,
    MBSYNC_RUN = 2'b10
  } mbsync_state_type;
  typedef struct packed {
    logic arm;
    logic run;
  } mbsync_sync_bus_type;
endpackage
`default_nettype wire

// [verilog/mbsync_ctrl.sv]
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "mbsync_params.svh"
module mbsync_ctrl (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [`MBSYNC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Synchronization bus
  input wire mbsync_pkg::mbsync_sync_bus_type sync_in_i,
  output mbsync_pkg::mbsync_sync_bus_type sync_out_o,
  input wire logic local_trigger_only_i,
  // Acquisition engine
  input wire logic meas_end_i,
  output logic acq_run_o
);
  import mbsync_pkg::*;

  mbsync_clk_role_type clk_role_q, clk_role_d;
  mbsync_trig_role_type trig_role_q, trig_role_d;
  mbsync_state_type state_q, state_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic blocking_q, blocking_d;
  logic block_pending_q, block_pending_d;
  logic [31:0] cmd_q, cmd_d;
  logic [31:0] run_cycles_q, run_cycles_d;
  logic [31:0] run_cnt_q, run_cnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  mbsync_sync_bus_type sync_out_q, sync_out_d;
  logic [31:0] status_w;
  logic clk_master_w;
  logic wr_cmd_w;
  logic take_w;
  logic acq_run_q, acq_run_d;

  // A write answers at once; a blocking run is held until the board stops.
  assign clk_master_w = (clk_role_q == MBSYNC_CLK_MASTER_STD) || (clk_role_q == MBSYNC_CLK_MASTER_STREAM);
  // A held blocking start must not be decoded again each cycle, or it would restart the run.
  assign take_w = !ack_q && !block_pending_q;
  assign wr_cmd_w = avs_write_i && take_w && (avs_address_i == `MBSYNC_OFS_COMMAND);

  always_comb begin
    status_w = 32'h00000000;
    status_w[`MBSYNC_ST_DONE_BIT] = done_q;
    status_w[`MBSYNC_ST_RUNNING_BIT] = (state_q == MBSYNC_RUN);
    status_w[`MBSYNC_ST_ARMED_BIT] = (state_q == MBSYNC_ARMED);
    status_w[`MBSYNC_ST_ERR_BIT] = err_q;
    status_w[`MBSYNC_ST_CLK_LSB +: 2] = clk_role_q;
    status_w[`MBSYNC_ST_TRIG_LSB +: 2] = trig_role_q;
    status_w[`MBSYNC_ST_BLOCK_BIT] = blocking_q;
  end

  always_comb begin
    clk_role_d = clk_role_q;
    trig_role_d = trig_role_q;
    state_d = state_q;
    done_d = done_q;
    err_d = err_q;
    blocking_d = blocking_q;
    block_pending_d = block_pending_q;
    cmd_d = cmd_q;
    run_cycles_d = run_cycles_q;
    run_cnt_d = run_cnt_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    sync_out_d = '0;
    // Arm from the bus if a peer master armed the group.
    if (sync_in_i.arm && (state_q == MBSYNC_IDLE)) begin
      state_d = MBSYNC_ARMED;
      done_d = 1'b0;
    end
    // Run state: count down, end on counter or external end.
    if (state_q == MBSYNC_RUN) begin
      run_cnt_d = run_cnt_q - 32'h00000001;
      if (meas_end_i || (run_cnt_q == 32'h00000001)) begin
        state_d = MBSYNC_IDLE;
        done_d = 1'b1;
        blocking_d = 1'b0;
      end
    end
    // A follower armed on the bus starts when a leader runs, unless local_trigger_only_i is set.
    if ((state_q == MBSYNC_ARMED) && sync_in_i.run && (trig_role_q == MBSYNC_TRIG_FOLLOWER)
        && !local_trigger_only_i) begin
      state_d = MBSYNC_RUN;
      run_cnt_d = run_cycles_q;
    end
    if (avs_write_i && take_w) begin
      if (avs_address_i == `MBSYNC_OFS_COMMAND) begin
        cmd_d = avs_writedata_i;
        if (avs_writedata_i == `MBSYNC_CMD_CLK_MASTER_STD) begin
          clk_role_d = MBSYNC_CLK_MASTER_STD;
        end else if (avs_writedata_i == `MBSYNC_CMD_CLK_MASTER_STREAM) begin
          clk_role_d = MBSYNC_CLK_MASTER_STREAM;
        end else if (avs_writedata_i == `MBSYNC_CMD_CLK_SLAVE_STD) begin
          clk_role_d = MBSYNC_CLK_SLAVE_STD;
        end else if (avs_writedata_i == `MBSYNC_CMD_TRIG_LEADER) begin
          trig_role_d = MBSYNC_TRIG_LEADER;
        end else if (avs_writedata_i == `MBSYNC_CMD_TRIG_FOLLOWER) begin
          trig_role_d = MBSYNC_TRIG_FOLLOWER;
        end else if (avs_writedata_i == `MBSYNC_CMD_ARM_GROUP) begin
          // Arming on a non-master would split the group, so it is refused.
          if (clk_master_w && (state_q == MBSYNC_IDLE)) begin
            state_d = MBSYNC_ARMED;
            done_d = 1'b0;
            sync_out_d.arm = 1'b1;
          end else begin
            err_d = 1'b1;
          end
        end else if ((avs_writedata_i == `MBSYNC_CMD_RUN) || (avs_writedata_i == `MBSYNC_CMD_RUN_BLOCKING)) begin
          // A start without arming still runs, but alone.
          if (state_q != MBSYNC_RUN) begin
            state_d = MBSYNC_RUN;
            run_cnt_d = run_cycles_q;
            done_d = 1'b0;
            blocking_d = (avs_writedata_i == `MBSYNC_CMD_RUN_BLOCKING);
            block_pending_d = (avs_writedata_i == `MBSYNC_CMD_RUN_BLOCKING);
            if (trig_role_q == MBSYNC_TRIG_LEADER) begin
              sync_out_d.run = 1'b1;
            end
          end else begin
            err_d = 1'b1;
          end
        end else begin
          err_d = 1'b1;
        end
      end else if (avs_address_i == `MBSYNC_OFS_STATUS) begin
        err_d = 1'b0;
      end else if (avs_address_i == `MBSYNC_OFS_RUN_CYCLES) begin
        run_cycles_d = (avs_writedata_i == 32'h00000000) ? 32'h00000001 : avs_writedata_i;
      end
      // A refused blocking start is answered at once like any other refusal.
      if (!block_pending_d) begin
        ack_d = 1'b1;
      end
    end else if (avs_read_i && take_w) begin
      if (avs_address_i == `MBSYNC_OFS_COMMAND) begin
        rdata_d = cmd_q;
      end else if (avs_address_i == `MBSYNC_OFS_STATUS) begin
        rdata_d = status_w;
      end else if (avs_address_i == `MBSYNC_OFS_RUN_CYCLES) begin
        rdata_d = run_cycles_q;
      end else begin
        rdata_d = 32'h00000000;
      end
      ack_d = 1'b1;
    end
    // A blocking start is acknowledged once the board has stopped.
    if (block_pending_q && (state_q != MBSYNC_RUN)) begin
      block_pending_d = 1'b0;
      ack_d = 1'b1;
    end
    acq_run_d = (state_d == MBSYNC_RUN);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_role_q <= MBSYNC_CLK_NONE;
      trig_role_q <= MBSYNC_TRIG_NONE;
      state_q <= MBSYNC_IDLE;
      done_q <= 1'b0;
      err_q <= 1'b0;
      blocking_q <= 1'b0;
      block_pending_q <= 1'b0;
      cmd_q <= 32'h00000000;
      run_cycles_q <= `MBSYNC_RUN_CYCLES_RST;
      run_cnt_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      sync_out_q <= '0;
      acq_run_q <= 1'b0;
    end else begin
      clk_role_q <= clk_role_d;
      trig_role_q <= trig_role_d;
      state_q <= state_d;
      done_q <= done_d;
      err_q <= err_d;
      blocking_q <= blocking_d;
      block_pending_q <= block_pending_d;
      cmd_q <= cmd_d;
      run_cycles_q <= run_cycles_d;
      run_cnt_q <= run_cnt_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      sync_out_q <= sync_out_d;
      acq_run_q <= acq_run_d;
    end
  end

  // Waitrequest stays high until the acknowledge flop rises.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !ack_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign sync_out_o = sync_out_q;
  assign acq_run_o = acq_run_q;

  property p_master_std;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_CLK_MASTER_STD) |=> (clk_role_q == MBSYNC_CLK_MASTER_STD);
  endproperty
  a_master_std: assert property (p_master_std) else $error("Clock master command not taken.");

  property p_slave_std;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_CLK_SLAVE_STD) |=> (clk_role_q == MBSYNC_CLK_SLAVE_STD);
  endproperty
  a_slave_std: assert property (p_slave_std) else $error("Clock slave command not taken.");

  property p_master_stream;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_CLK_MASTER_STREAM) |=> (clk_role_q == MBSYNC_CLK_MASTER_STREAM);
  endproperty
  a_master_stream: assert property (p_master_stream) else $error("Stream master command not taken.");

  property p_arm;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_ARM_GROUP) && clk_master_w && (state_q == MBSYNC_IDLE)
      |=> (state_q == MBSYNC_ARMED) && sync_out_o.arm;
  endproperty
  a_arm: assert property (p_arm) else $error("Arm did not reach the bus.");

  property p_run;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_RUN) && (state_q != MBSYNC_RUN) |=> acq_run_o && !avs_waitrequest_o;
  endproperty
  a_run: assert property (p_run) else $error("Start command not taken.");

  property p_block;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    block_pending_q && acq_run_o |-> avs_waitrequest_o;
  endproperty
  a_block: assert property (p_block) else $error("Blocking start completed early.");

  property p_done;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    acq_run_o && meas_end_i |=> done_q && !acq_run_o;
  endproperty
  a_done: assert property (p_done) else $error("Done not raised at end.");

  property p_leader;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_TRIG_LEADER) |=> (trig_role_q == MBSYNC_TRIG_LEADER);
  endproperty
  a_leader: assert property (p_leader) else $error("Trigger leader not taken.");

  property p_follower;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_TRIG_FOLLOWER) |=> (trig_role_q == MBSYNC_TRIG_FOLLOWER);
  endproperty
  a_follower: assert property (p_follower) else $error("Trigger follower not taken.");

  property p_arm_refused;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_cmd_w && (avs_writedata_i == `MBSYNC_CMD_ARM_GROUP) && !clk_master_w |=> err_q && !sync_out_o.arm;
  endproperty
  a_arm_refused: assert property (p_arm_refused) else $error("Arm on a non-master not refused.");

  property p_block_ack;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    block_pending_q && !acq_run_o |=> !avs_waitrequest_o;
  endproperty
  a_block_ack: assert property (p_block_ack) else $error("Blocking start not answered after stop.");

  property p_follow_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == MBSYNC_ARMED) && sync_in_i.run && (trig_role_q == MBSYNC_TRIG_FOLLOWER) && !local_trigger_only_i
      |=> acq_run_o;
  endproperty
  a_follow_start: assert property (p_follow_start) else $error("Armed follower did not start.");

  property p_local_only;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_q == MBSYNC_ARMED) && sync_in_i.run && local_trigger_only_i && !wr_cmd_w |=> !acq_run_o;
  endproperty
  a_local_only: assert property (p_local_only) else $error("Local-only board followed the bus.");
endmodule
`default_nettype wire

// [test/mbsync_peer_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mbsync_peer_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Bench requests
  input wire logic arm_req_i,
  input wire logic run_req_i,
  input wire logic [7:0] end_after_i,
  // Board side
  input wire logic acq_run_i,
  output var mbsync_pkg::mbsync_sync_bus_type sync_o,
  output var logic meas_end_o
);
  import mbsync_pkg::*;
  logic [7:0] cnt_q;
  // The peer clock master pulses arm and a peer trigger leader pulses run, each one cycle after the bench asks; run is not tied to arming.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_o <= '0;
      cnt_q <= 8'h00;
    end else begin
      sync_o.arm <= arm_req_i;
      sync_o.run <= run_req_i;
      cnt_q <= acq_run_i ? cnt_q + 8'h01 : 8'h00;
    end
  end
  // End stands during the end_after-th running cycle, so the board runs exactly that many cycles.
  always_comb begin
    meas_end_o = acq_run_i && (end_after_i != 8'h00) && (cnt_q + 8'h01 == end_after_i);
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mbsync_params.svh"
module testbench;
  import mbsync_pkg::*;
  logic core_clk_i, rst_n_i, rd_q, wr_q, wreq, loc_only, meas_end, acq_run, arm_req, run_req;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, st;
  logic [7:0] end_after;
  mbsync_sync_bus_type sync_in, sync_out;
  int errors, n_tests, acq_cnt, arm_cnt, run_cnt, base;
  logic [31:0] cmd_tab [5] = '{`MBSYNC_CMD_CLK_MASTER_STD, `MBSYNC_CMD_CLK_MASTER_STREAM,
    `MBSYNC_CMD_CLK_SLAVE_STD, `MBSYNC_CMD_TRIG_LEADER, `MBSYNC_CMD_TRIG_FOLLOWER};
  logic [1:0] role_tab [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  mbsync_ctrl dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_q),
    .avs_write_i(wr_q), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .sync_in_i(sync_in), .sync_out_o(sync_out), .local_trigger_only_i(loc_only), .meas_end_i(meas_end),
    .acq_run_o(acq_run));
  mbsync_peer_model peer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .arm_req_i(arm_req),
    .run_req_i(run_req), .end_after_i(end_after), .acq_run_i(acq_run), .sync_o(sync_in),
    .meas_end_o(meas_end));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // Counting on the falling edge keeps the counts settled before a task checks them at the next rising edge.
  always @(negedge core_clk_i) begin
    if (acq_run === 1'b1) acq_cnt++;
    if (sync_out.arm === 1'b1) arm_cnt++;
    if (sync_out.run === 1'b1) run_cnt++;
  end
  // Each transfer first lets an edge pass, so a released request never rises again in the same step.
  // A missing answer is caught by the watchdog, not here.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wr_q <= w;
    rd_q <= ~w;
    wdata <= d;
    do begin
      @(posedge core_clk_i);
    end while (wreq !== 1'b0);
    st = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  task automatic wcmd(input logic [31:0] c);
    xfer(1'b1, `MBSYNC_OFS_COMMAND, c);
  endtask
  task automatic rstat;
    xfer(1'b0, `MBSYNC_OFS_STATUS, 32'h00000000);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic pulse(input logic is_run);
    @(posedge core_clk_i);
    arm_req <= ~is_run;
    run_req <= is_run;
    @(posedge core_clk_i);
    arm_req <= 1'b0;
    run_req <= 1'b0;
  endtask
  // Waits for the run to begin, then polls status until running drops; a run that never ends counts as wrong.
  task automatic wait_end;
    for (int n = 0; n < 40 && acq_run !== 1'b1; n++) @(posedge core_clk_i);
    rstat;
    for (int n = 0; n < 40 && st[`MBSYNC_ST_RUNNING_BIT] !== 1'b0; n++) rstat;
    chk("done bit", 32'h1, 32'(st[`MBSYNC_ST_DONE_BIT]));
    chk("running bit", 32'h0, 32'(st[`MBSYNC_ST_RUNNING_BIT]));
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    tally_and_finish();
  end
  initial begin
    {rst_n_i, rd_q, wr_q, loc_only, arm_req, run_req, addr, wdata, end_after} = '0;
    repeat (5) @(posedge core_clk_i);
    chk("waitrequest in reset", 32'h1, 32'(wreq));
    rst_n_i <= 1'b1;
    rstat;
    chk("status after reset", 32'h0, st);
    for (int i = 0; i < 5; i++) begin
      wcmd(cmd_tab[i]);
      xfer(1'b0, `MBSYNC_OFS_COMMAND, 32'h0);
      chk("command readback", cmd_tab[i], st);
      rstat;
      chk("role field", 32'(role_tab[i]), 32'(i < 3 ? st[5:4] : st[7:6]));
    end
    $display("test roles finished");
    wcmd(`MBSYNC_CMD_ARM_GROUP);
    rstat;
    chk("arm refused on clock slave", 32'h1, 32'(st[`MBSYNC_ST_ERR_BIT]));
    chk("no arm pulse", 32'h0, 32'(arm_cnt));
    xfer(1'b1, `MBSYNC_OFS_STATUS, 32'h0);
    rstat;
    chk("error cleared", 32'h0, 32'(st[`MBSYNC_ST_ERR_BIT]));
    $display("test refusal finished");
    xfer(1'b1, `MBSYNC_OFS_RUN_CYCLES, 32'h00000003);
    wcmd(`MBSYNC_CMD_CLK_MASTER_STD);
    wcmd(`MBSYNC_CMD_TRIG_LEADER);
    wcmd(`MBSYNC_CMD_ARM_GROUP);
    chk("arm pulse", 32'h1, 32'(arm_cnt));
    rstat;
    chk("armed bit", 32'h1, 32'(st[`MBSYNC_ST_ARMED_BIT]));
    wcmd(`MBSYNC_CMD_RUN);
    chk("leader run pulse", 32'h1, 32'(run_cnt));
    wait_end();
    chk("run length", 32'h3, 32'(acq_cnt));
    $display("test leader finished");
    wcmd(`MBSYNC_CMD_CLK_SLAVE_STD);
    wcmd(`MBSYNC_CMD_TRIG_FOLLOWER);
    loc_only <= 1'b1;
    pulse(1'b0);
    rstat;
    chk("follower armed by peer", 32'h1, 32'(st[`MBSYNC_ST_ARMED_BIT]));
    pulse(1'b1);
    repeat (4) @(posedge core_clk_i);
    chk("local trigger ignores peer run", 32'h3, 32'(acq_cnt));
    loc_only <= 1'b0;
    end_after <= 8'h02;
    pulse(1'b1);
    wait_end();
    chk("ended by measurement end", 32'h5, 32'(acq_cnt));
    $display("test follower finished");
    end_after <= 8'h00;
    wcmd(`MBSYNC_CMD_CLK_MASTER_STD);
    wcmd(`MBSYNC_CMD_TRIG_LEADER);
    wcmd(`MBSYNC_CMD_ARM_GROUP);
    base = acq_cnt;
    wcmd(`MBSYNC_CMD_RUN_BLOCKING);
    chk("blocking start held until stop", 32'(base + 3), 32'(acq_cnt));
    rstat;
    chk("blocking status", 32'h001, st & 32'h00000103);
    xfer(1'b0, 4'hC, 32'h0);
    chk("unmapped read", 32'h0, st);
    $display("test blocking finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
